// ===== pkg/ccd_blc_map.vh
// constants for the black level calibration loop
// Operation
// - clip calibration samples at 511
// - converter output bus stays unclipped
// - average count select, 4 to 512, reset 128
// - averaging spans lines until count reached
// - subtract target code, steer DACs against sign
// - fine accumulator moves one count per update
// - fine wrap reloads mid-scale, steps coarse
// - fast mode coarse step above 128 codes
// - fast convergence enable, reset enabled
// - deadband select off/narrow/medium/wide
// - hold freezes both accumulators, resets off
// - manual mode loads accumulators from writes
// - manual enable bit, resets inactive
// - take black pixels only in calibration window
// - apply new codes only during black time
// - clear averager, wait programmed lines
// - per-pulse polarity bit, one is active high
// - every reset makes all pulses active low
// - black switches on while black pulse active
// - video tracking starts delay after black end
// - power-down forces hold, keeps registers
`ifndef CCD_BLC_MAP_VH
`define CCD_BLC_MAP_VH

// sample and accumulator widths
`define BLC_SAMPLE_W 12
`define BLC_CLIP_MAX 9'h1FF
`define BLC_COARSE_W 9
`define BLC_FINE_W 10
`define BLC_FINE_MID 10'h200
`define BLC_COARSE_MID 9'h100
`define BLC_COARSE_MAX 9'h1FF

// calibration settings word fields
`define CFG_AVG_LSB 0
`define CFG_AVG_MSB 2
`define CFG_SPEEDUP 3
`define CFG_DNS_LSB 4
`define CFG_DNS_MSB 5
`define CFG_HOLD 6
`define CFG_MANUAL 7
// avg 128, speedup on, deadband off, hold off, manual off
`define CFG_RESET 8'h0D

// target register reset value
`define TARGET_RESET 10'h020

// wait count parts: low byte and high nibble
`define WAIT_LO_RESET 8'h00
`define WAIT_HI_RESET 4'h0

// polarity bits: black, video, converter, clamp, cal window
`define POL_BLACK 0
`define POL_VIDEO 1
`define POL_CONV 2
`define POL_CLAMP 3
`define POL_CAL 4
`define POL_RESET 5'h00

// deadband widths in converter codes
`define DNS_NARROW 11'h002
`define DNS_MEDIUM 11'h004
`define DNS_WIDE 11'h008
// fast step threshold in codes
`define FAST_THRESH 11'h080
// coarse step at the lowest gain octave
`define COARSE_STEP_BASE 9'h010
// video track delay reset
`define TRACK_DELAY_RESET 3'h0

`endif

// ===== logic/blc_pixel_clip_avg.v
// clipper and power-of-two averager for black pixels
`timescale 1ns/100ps
`include "ccd_blc_map.vh"
module blc_pixel_clip_avg (
  input wire sys_clk,
  input wire reset_n,
  input wire clear,
  input wire sample_en,
  input wire [11:0] sample,
  input wire [2:0] avg_sel,
  output wire done,
  output reg [8:0] average
);
  reg [17:0] sum_reg; // room for 512 clipped samples
  reg [9:0] count_reg; // samples taken so far
  wire [8:0] clipped; // calibration copy only
  wire [10:0] target_count; // 4 << avg_sel
  wire [3:0] shift; // log2 of count

  // bright pixels are pinned so one hot pixel adds at most 511 to the sum
  assign clipped = (sample > {3'h0, `BLC_CLIP_MAX}) ? `BLC_CLIP_MAX : sample[8:0];
  assign target_count = 11'h004 << avg_sel;
  assign shift = {1'b0, avg_sel} + 4'h2;
  assign done = ({1'b0, count_reg} >= target_count);

  // sum keeps running across lines until the count is met
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sum_reg <= 18'h00000;
      count_reg <= 10'h000;
    end else if (clear) begin
      sum_reg <= 18'h00000;
      count_reg <= 10'h000;
    end else if (sample_en && !done) begin
      sum_reg <= sum_reg + {9'h000, clipped};
      count_reg <= count_reg + 10'h001;
    end
  end

  // mean by shift; exact because every count is a power of two
  wire [17:0] mean_full; // clipped samples keep the top bits zero
  assign mean_full = sum_reg >> shift;
  always @* begin
    average = mean_full[8:0];
  end
endmodule // blc_pixel_clip_avg

// ===== logic/ccd_black_level_calibration.v
// black level offset calibration loop with pulse polarity and phases
`timescale 1ns/100ps
`include "ccd_blc_map.vh"
module ccd_black_level_calibration (
  input wire sys_clk,
  input wire reset_n,
  input wire soft_reset,
  input wire black_sample_pulse,
  input wire video_sample_pulse,
  input wire converter_clock,
  input wire clamp_pulse,
  input wire cal_window_pulse,
  input wire [11:0] adc_sample,
  input wire [9:0] gain_code,
  input wire power_down_pin,
  input wire power_down_bit,
  input wire target_wr,
  input wire [9:0] target_wdata,
  input wire cfg_wr,
  input wire [7:0] cfg_wdata,
  input wire coarse_wr,
  input wire [8:0] coarse_wdata,
  input wire fine_wr,
  input wire [9:0] fine_wdata,
  input wire wait_lo_wr,
  input wire [7:0] wait_lo_wdata,
  input wire wait_hi_wr,
  input wire [3:0] wait_hi_wdata,
  input wire polarity_wr,
  input wire [4:0] polarity_wdata,
  input wire delay_wr,
  input wire [2:0] delay_wdata,
  output reg [11:0] adc_data_out,
  output reg [8:0] coarse_dac_code,
  output reg [9:0] fine_dac_code,
  output reg [9:0] target_readback,
  output reg [7:0] cfg_readback,
  output reg [4:0] polarity_readback,
  output reg black_switch_on,
  output reg video_track_on,
  output reg clamp_active,
  output reg iteration_done,
  output reg [8:0] last_average
);
  // loop states
  localparam ST_COLLECT = 2'b00;
  localparam ST_CALC = 2'b01;
  localparam ST_APPLY = 2'b10;
  localparam ST_WAIT = 2'b11;

  reg [7:0] wait_lo_reg; // low part of line wait
  reg [3:0] wait_hi_reg; // high part of line wait
  reg [2:0] video_track_delay; // cycles after black end
  reg [1:0] state_reg; // loop state
  reg [11:0] line_cnt_reg; // lines waited
  reg [8:0] coarse_pend_reg; // computed coarse code
  reg [9:0] fine_pend_reg; // computed fine code
  reg conv_act_d_reg; // previous converter phase
  reg black_act_d_reg; // previous black phase
  reg video_act_d_reg; // previous video phase
  reg cal_act_d_reg; // previous window phase
  reg [2:0] track_cnt_reg; // video delay counter
  reg track_arm_reg; // delay running
  reg [8:0] coarse_next; // update result
  reg [9:0] fine_next; // update result
  reg [10:0] db_width; // deadband width
  reg [8:0] fast_step; // coarse step from gain

  wire [2:0] average_count_sel;
  wire speedup_enable;
  wire [1:0] noise_deadband_sel;
  wire hold_bit;
  wire manual_offset_enable;
  wire [7:0] target_black_code;
  wire [11:0] iteration_wait_lines;
  wire black_act, video_act, conv_act, cal_act;
  wire sample_strobe; // entry into conversion phase
  wire line_end; // calibration window closes
  wire freeze; // hold or power-down
  wire avg_done;
  wire [8:0] average;
  wire avg_clear;
  wire [10:0] diff; // average minus target, signed
  wire [10:0] mag;
  wire diff_neg;

  assign average_count_sel = cfg_readback[`CFG_AVG_MSB:`CFG_AVG_LSB];
  assign speedup_enable = cfg_readback[`CFG_SPEEDUP];
  assign noise_deadband_sel = cfg_readback[`CFG_DNS_MSB:`CFG_DNS_LSB];
  assign hold_bit = cfg_readback[`CFG_HOLD];
  assign manual_offset_enable = cfg_readback[`CFG_MANUAL];
  // upper two target bits are ignored; codes 0 and 1 are the writer's problem
  assign target_black_code = target_readback[7:0];
  assign iteration_wait_lines = {wait_hi_reg, wait_lo_reg};

  // polarity: bit zero means pin low is active
  assign black_act = black_sample_pulse ^ ~polarity_readback[`POL_BLACK];
  assign video_act = video_sample_pulse ^ ~polarity_readback[`POL_VIDEO];
  assign conv_act = converter_clock ^ ~polarity_readback[`POL_CONV];
  assign cal_act = cal_window_pulse ^ ~polarity_readback[`POL_CAL];

  // converter converts as its clock enters the active phase; the generator
  // must align that edge with the black pulse end
  assign sample_strobe = conv_act && !conv_act_d_reg;
  assign line_end = cal_act_d_reg && !cal_act;
  assign freeze = hold_bit || power_down_pin || power_down_bit;

  // only window pixels feed the averager, and only while collecting
  assign avg_clear = (state_reg == ST_APPLY);
  assign diff = {2'b00, average} - {3'b000, target_black_code};
  assign diff_neg = diff[10];
  assign mag = diff_neg ? (11'h000 - diff) : diff;

  blc_pixel_clip_avg u_avg (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .clear(avg_clear),
    .sample_en(sample_strobe && cal_act && (state_reg == ST_COLLECT)),
    .sample(adc_sample),
    .avg_sel(average_count_sel),
    .done(avg_done),
    .average(average)
  );

  // software-written settings; reset pin and reset bit both restore them
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      target_readback <= `TARGET_RESET;
      cfg_readback <= `CFG_RESET;
      wait_lo_reg <= `WAIT_LO_RESET;
      wait_hi_reg <= `WAIT_HI_RESET;
      polarity_readback <= `POL_RESET;
      video_track_delay <= `TRACK_DELAY_RESET;
    end else if (soft_reset) begin
      target_readback <= `TARGET_RESET;
      cfg_readback <= `CFG_RESET;
      wait_lo_reg <= `WAIT_LO_RESET;
      wait_hi_reg <= `WAIT_HI_RESET;
      polarity_readback <= `POL_RESET;
      video_track_delay <= `TRACK_DELAY_RESET;
    end else begin
      // power-down does not touch any of these
      if (target_wr) target_readback <= target_wdata;
      if (cfg_wr) cfg_readback <= cfg_wdata;
      if (wait_lo_wr) wait_lo_reg <= wait_lo_wdata;
      if (wait_hi_wr) wait_hi_reg <= wait_hi_wdata;
      if (polarity_wr) polarity_readback <= polarity_wdata;
      if (delay_wr) video_track_delay <= delay_wdata;
    end
  end

  // raw converter word goes out untouched
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      adc_data_out <= 12'h000;
    end else if (sample_strobe) begin
      adc_data_out <= adc_sample;
    end
  end

  // deadband width and fast step size
  always @* begin
    db_width = 11'h000;
    fast_step = `COARSE_STEP_BASE;
    case (noise_deadband_sel)
      2'b01: db_width = `DNS_NARROW;
      2'b10: db_width = `DNS_MEDIUM;
      2'b11: db_width = `DNS_WIDE;
      default: db_width = 11'h000;
    endcase
    // gain doubles every 128 codes, so halve the step per octave up to octave 4, then hold at one code
    if (gain_code[9:7] > 3'h4) begin
      fast_step = `COARSE_STEP_BASE >> 4;
    end else begin
      fast_step = `COARSE_STEP_BASE >> gain_code[9:7];
    end
  end

  // one update: deadband, fast coarse step, or single fine count
  always @* begin
    coarse_next = coarse_dac_code;
    fine_next = fine_dac_code;
    if ((noise_deadband_sel != 2'b00) && (mag <= db_width)) begin
      coarse_next = coarse_dac_code;
    end else if (speedup_enable && (mag > `FAST_THRESH)) begin
      if (diff_neg) begin
        // output too low: raise coarse, saturating at the top
        if (coarse_dac_code > (`BLC_COARSE_MAX - fast_step)) begin
          coarse_next = `BLC_COARSE_MAX;
        end else begin
          coarse_next = coarse_dac_code + fast_step;
        end
      end else begin
        if (coarse_dac_code < fast_step) begin
          coarse_next = 9'h000;
        end else begin
          coarse_next = coarse_dac_code - fast_step;
        end
      end
    end else if (mag != 11'h000) begin
      if (diff_neg) begin
        if (fine_dac_code == 10'h3FF) begin
          // fine would overflow: recentre and carry into coarse
          fine_next = `BLC_FINE_MID;
          if (coarse_dac_code != `BLC_COARSE_MAX) coarse_next = coarse_dac_code + 9'h001;
        end else begin
          fine_next = fine_dac_code + 10'h001;
        end
      end else begin
        if (fine_dac_code == 10'h000) begin
          fine_next = `BLC_FINE_MID;
          if (coarse_dac_code != 9'h000) coarse_next = coarse_dac_code - 9'h001;
        end else begin
          fine_next = fine_dac_code - 10'h001;
        end
      end
    end
  end

  // iteration sequencer and accumulators
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_COLLECT;
      line_cnt_reg <= 12'h000;
      coarse_pend_reg <= `BLC_COARSE_MID;
      fine_pend_reg <= `BLC_FINE_MID;
      coarse_dac_code <= `BLC_COARSE_MID;
      fine_dac_code <= `BLC_FINE_MID;
      iteration_done <= 1'b0;
      last_average <= 9'h000;
    end else begin
      iteration_done <= 1'b0;
      if (freeze) begin
        // nothing moves in hold, not even manual loads
        state_reg <= state_reg;
      end else if (manual_offset_enable) begin
        // automatic loop parked; direct loads only
        state_reg <= ST_COLLECT;
        if (coarse_wr) coarse_dac_code <= coarse_wdata;
        if (fine_wr) fine_dac_code <= fine_wdata;
      end else begin
        case (state_reg)
          ST_COLLECT: begin
            if (avg_done) state_reg <= ST_CALC;
          end
          ST_CALC: begin
            coarse_pend_reg <= coarse_next;
            fine_pend_reg <= fine_next;
            last_average <= average;
            state_reg <= ST_APPLY;
          end
          ST_APPLY: begin
            // codes change only while black pixels are under the window
            if (cal_act) begin
              coarse_dac_code <= coarse_pend_reg;
              fine_dac_code <= fine_pend_reg;
              iteration_done <= 1'b1;
              line_cnt_reg <= 12'h000;
              state_reg <= (iteration_wait_lines == 12'h000) ? ST_COLLECT : ST_WAIT;
            end
          end
          ST_WAIT: begin
            if (line_end) begin
              if (line_cnt_reg + 12'h001 >= iteration_wait_lines) begin
                state_reg <= ST_COLLECT;
              end
              line_cnt_reg <= line_cnt_reg + 12'h001;
            end
          end
          default: state_reg <= ST_COLLECT;
        endcase
      end
    end
  end

  // phase history for edge detection
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      conv_act_d_reg <= 1'b0;
      black_act_d_reg <= 1'b0;
      video_act_d_reg <= 1'b0;
      cal_act_d_reg <= 1'b0;
    end else begin
      conv_act_d_reg <= conv_act;
      black_act_d_reg <= black_act;
      video_act_d_reg <= video_act;
      cal_act_d_reg <= cal_act;
    end
  end

  // pixel rate switch controls; delay is counted in clock cycles
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      black_switch_on <= 1'b0;
      clamp_active <= 1'b0;
      video_track_on <= 1'b0;
      track_cnt_reg <= 3'h0;
      track_arm_reg <= 1'b0;
    end else begin
      black_switch_on <= black_act;
      clamp_active <= clamp_pulse ^ ~polarity_readback[`POL_CLAMP];
      if (black_act_d_reg && !black_act) begin
        // black pulse ended: start the track delay
        track_cnt_reg <= 3'h0;
        track_arm_reg <= (video_track_delay != 3'h0);
        video_track_on <= (video_track_delay == 3'h0);
      end else if (track_arm_reg) begin
        if (track_cnt_reg + 3'h1 >= video_track_delay) begin
          track_arm_reg <= 1'b0;
          video_track_on <= 1'b1;
        end
        track_cnt_reg <= track_cnt_reg + 3'h1;
      end else if (video_act_d_reg && !video_act) begin
        // video level held at the trailing edge of its pulse
        video_track_on <= 1'b0;
      end
    end
  end
endmodule // ccd_black_level_calibration

// ===== tb/blc_checker_assertions.sv
// concurrent checks on the black level calibration ports
`timescale 1ns/100ps
module blc_checker (
  input wire sys_clk,
  input wire reset_n,
  input wire soft_reset,
  input wire black_sample_pulse,
  input wire converter_clock,
  input wire clamp_pulse,
  input wire cal_window_pulse,
  input wire [11:0] adc_sample,
  input wire power_down_pin,
  input wire power_down_bit,
  input wire target_wr,
  input wire [9:0] target_wdata,
  input wire cfg_wr,
  input wire [7:0] cfg_wdata,
  input wire coarse_wr,
  input wire [8:0] coarse_wdata,
  input wire [11:0] adc_data_out,
  input wire [8:0] coarse_dac_code,
  input wire [9:0] fine_dac_code,
  input wire [9:0] target_readback,
  input wire [7:0] cfg_readback,
  input wire [4:0] polarity_readback,
  input wire black_switch_on,
  input wire clamp_active,
  input wire iteration_done
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // active levels follow the programmed polarity
  wire conv_act = converter_clock == polarity_readback[2];
  wire cal_act = cal_window_pulse == polarity_readback[4];
  // any freeze source
  wire frz = cfg_readback[6] | power_down_pin | power_down_bit;
  // first cycle of a conversion, guarded against pre-reset history
  sequence s_strobe;
    conv_act && !$past(conv_act) && $past(reset_n);
  endsequence
  // fine wrapping downward in automatic mode
  sequence s_wrap_down;
    $past(fine_dac_code) == 10'h000 && fine_dac_code == 10'h200 && !$past(cfg_readback[7])
      && $past(reset_n) && $past(coarse_dac_code) != 9'h000;
  endsequence
  property p_unclipped;
    s_strobe |=> adc_data_out == $past(adc_sample);
  endproperty
  a_unclipped: assert property (p_unclipped) else $error("output bus not raw sample");
  property p_hold;
    frz |=> $stable(coarse_dac_code) && $stable(fine_dac_code);
  endproperty
  a_hold: assert property (p_hold) else $error("codes moved while frozen");
  property p_fine_step;
    !$past(cfg_readback[7]) && $past(reset_n) && $changed(fine_dac_code) |->
      fine_dac_code == $past(fine_dac_code) + 10'h001 ||
      fine_dac_code == $past(fine_dac_code) - 10'h001 || fine_dac_code == 10'h200;
  endproperty
  a_fine_step: assert property (p_fine_step) else $error("fine step too large");
  property p_wrap;
    s_wrap_down |-> coarse_dac_code == $past(coarse_dac_code) - 9'h001;
  endproperty
  a_wrap: assert property (p_wrap) else $error("coarse not stepped on wrap");
  property p_done;
    iteration_done |-> (cal_act || $past(cal_act)) ##1 !iteration_done;
  endproperty
  a_done: assert property (p_done) else $error("apply outside black time");
  property p_black_sw;
    $past(reset_n) |-> black_switch_on == $past(black_sample_pulse == polarity_readback[0]);
  endproperty
  a_black_sw: assert property (p_black_sw) else $error("black switch wrong");
  property p_clamp;
    $past(reset_n) |-> clamp_active == $past(clamp_pulse == polarity_readback[3]);
  endproperty
  a_clamp: assert property (p_clamp) else $error("clamp level wrong");
  property p_cfg_rb;
    cfg_wr && !soft_reset |=> cfg_readback == $past(cfg_wdata);
  endproperty
  a_cfg_rb: assert property (p_cfg_rb) else $error("settings not stored");
  property p_target_rb;
    target_wr && !soft_reset |=> target_readback == $past(target_wdata);
  endproperty
  a_target_rb: assert property (p_target_rb) else $error("target not stored");
  property p_manual;
    coarse_wr && cfg_readback[7] && !frz |=> coarse_dac_code == $past(coarse_wdata);
  endproperty
  a_manual: assert property (p_manual) else $error("manual coarse not loaded");
endmodule // blc_checker

bind ccd_black_level_calibration blc_checker u_blc_checker (.sys_clk(sys_clk),
  .reset_n(reset_n), .soft_reset(soft_reset), .black_sample_pulse(black_sample_pulse),
  .converter_clock(converter_clock), .clamp_pulse(clamp_pulse),
  .cal_window_pulse(cal_window_pulse), .adc_sample(adc_sample),
  .power_down_pin(power_down_pin), .power_down_bit(power_down_bit), .target_wr(target_wr),
  .target_wdata(target_wdata), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .coarse_wr(coarse_wr),
  .coarse_wdata(coarse_wdata), .adc_data_out(adc_data_out),
  .coarse_dac_code(coarse_dac_code), .fine_dac_code(fine_dac_code),
  .target_readback(target_readback), .cfg_readback(cfg_readback),
  .polarity_readback(polarity_readback), .black_switch_on(black_switch_on),
  .clamp_active(clamp_active), .iteration_done(iteration_done));

// ===== tb/ccd_timing_gen.sv
// timing generator model: pixel and line pulses plus converter words
`timescale 1ns/100ps
module ccd_timing_gen (
  input wire sys_clk,
  input wire reset_n,
  input wire run,
  input wire [4:0] pol,
  input wire [11:0] level,
  output wire black_sample_pulse,
  output wire video_sample_pulse,
  output wire converter_clock,
  output wire clamp_pulse,
  output wire cal_window_pulse,
  output wire [11:0] adc_sample
);
  // four cycles a pixel, twelve pixels a line
  logic [5:0] ph_reg;
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ph_reg <= 6'h00;
    end else begin
      ph_reg <= (ph_reg == 6'h2F) ? 6'h00 : ph_reg + 6'h01;
    end
  end
  // all pulses stand inactive while stopped, so no stray samples
  wire blk_a = run && ph_reg[1:0] == 2'h0;
  wire conv_a = run && (ph_reg[1] ^ ph_reg[0]);
  wire vid_a = run && ph_reg[1:0] == 2'h2;
  wire cal_a = run && ph_reg[5:2] < 4'h8;
  wire clp_a = run && ph_reg[5:2] > 4'h9;
  // active level equals the polarity bit
  assign black_sample_pulse = blk_a ~^ pol[0];
  assign video_sample_pulse = vid_a ~^ pol[1];
  assign converter_clock = conv_a ~^ pol[2];
  assign clamp_pulse = clp_a ~^ pol[3];
  assign cal_window_pulse = cal_a ~^ pol[4];
  // outside conversion the word is inverted, not held; pixels outside the
  // window are bright, so a stray sample there would lift the mean
  assign adc_sample = !conv_a ? ~level : cal_a ? level : 12'hFFF;
endmodule // ccd_timing_gen

// ===== tb/test_ccd_black_level_calibration.sv
// self-checking bench for the black level calibration loop
`timescale 1ns/100ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin err_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module test_ccd_black_level_calibration;
  logic sys_clk = 1'b0, reset_n = 1'b0, run = 1'b0, pd_pin = 1'b0, pd_bit = 1'b0;
  logic [8:0] st = 9'h000; // write strobes, bit 8 is soft reset
  logic [11:0] wd = 12'h000, level = 12'h000;
  logic [9:0] gain = 10'h000;
  logic [4:0] pol = 5'h00;
  wire bsp, vsp, cck, clp, cwp, bsw, vtr, clmp, done;
  wire [11:0] smp, dout;
  wire [8:0] coarse, avg;
  wire [9:0] fine, trb;
  wire [7:0] crb;
  wire [4:0] prb;
  int err_count = 0, samples_checked = 0, k, i;
  always #5 sys_clk = ~sys_clk;
  ccd_timing_gen u_ccd_timing_gen (.sys_clk(sys_clk), .reset_n(reset_n), .run(run),
    .pol(pol), .level(level), .black_sample_pulse(bsp), .video_sample_pulse(vsp),
    .converter_clock(cck), .clamp_pulse(clp), .cal_window_pulse(cwp), .adc_sample(smp));
  ccd_black_level_calibration u_ccd_black_level_calibration (.sys_clk(sys_clk),
    .reset_n(reset_n), .soft_reset(st[8]), .black_sample_pulse(bsp), .video_sample_pulse(vsp),
    .converter_clock(cck), .clamp_pulse(clp), .cal_window_pulse(cwp), .adc_sample(smp),
    .gain_code(gain), .power_down_pin(pd_pin), .power_down_bit(pd_bit), .target_wr(st[0]),
    .target_wdata(wd[9:0]), .cfg_wr(st[1]), .cfg_wdata(wd[7:0]), .coarse_wr(st[2]),
    .coarse_wdata(wd[8:0]), .fine_wr(st[3]), .fine_wdata(wd[9:0]), .wait_lo_wr(st[4]),
    .wait_lo_wdata(wd[7:0]), .wait_hi_wr(st[5]), .wait_hi_wdata(wd[3:0]),
    .polarity_wr(st[6]), .polarity_wdata(wd[4:0]), .delay_wr(st[7]),
    .delay_wdata(wd[2:0]), .adc_data_out(dout), .coarse_dac_code(coarse),
    .fine_dac_code(fine), .target_readback(trb), .cfg_readback(crb),
    .polarity_readback(prb), .black_switch_on(bsw), .video_track_on(vtr),
    .clamp_active(clmp), .iteration_done(done), .last_average(avg));
  // one-cycle strobe write, readback settled on return
  task wr(input [3:0] w, input [11:0] d);
    @(posedge sys_clk);
    #1 st[w] = 1'b1;
    wd = d;
    @(posedge sys_clk);
    #1 st = 9'h000;
  endtask
  // full reset so each case starts from known codes and an empty averager
  task restart;
    run = 1'b0;
    @(posedge sys_clk);
    #1 reset_n = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 reset_n = 1'b1;
  endtask
  // wait for the next applied iteration; k holds the cycles waited
  task wait_done;
    k = 0;
    do begin
      @(posedge sys_clk);
      #1;
      k++;
    end while (done !== 1'b1 && k < 3000);
    `CHK(k < 3000, 1'b1)
  endtask
  // configure, start the pulses, wait for n applied iterations
  task go(input [7:0] c, input [11:0] t, input [11:0] l, input int n);
    restart;
    wr(4'h1, {4'h0, c});
    wr(4'h0, t);
    level = l;
    run = 1'b1;
    for (i = 0; i < n; i++) wait_done;
    @(posedge sys_clk);
    #1;
  endtask
  task end_of_test;
    $display("mismatches %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // hang guard, far beyond the few thousand cycles needed
  initial begin
    #500000;
    err_count++;
    end_of_test;
  end
  initial begin
    restart;
    `CHK(crb, 8'h0D)
    `CHK(trb, 10'h020)
    `CHK(prb, 5'h00)
    `CHK({coarse, fine}, {9'h100, 10'h200})
    // bright black level: clipped, fine walks down one count per iteration
    go(8'h00, 12'h3FF, 12'h804, 2);
    `CHK(fine, 10'h1FE)
    `CHK(coarse, 9'h100)
    `CHK(avg, 9'h1FF)
    `CHK(dout, 12'h804)
    `CHK(trb, 10'h3FF)
    // 32 samples need four lines of eight; negative difference
    go(8'h03, 12'h0FF, 12'h0F0, 1);
    `CHK(fine, 10'h201)
    `CHK(avg, 9'h0F0)
    // speedup: coarse step shrinks with gain
    for (int g = 0; g < 3; g++) begin
      gain = (g == 0) ? 10'h000 : (g == 1) ? 10'h080 : 10'h380;
      go(8'h08, 12'h0FF, 12'h804, 1);
      `CHK(coarse, (g == 0) ? 9'h0F0 : (g == 1) ? 9'h0F8 : 9'h0FF)
      `CHK(fine, 10'h200)
    end
    gain = 10'h000;
    // difference equal to each deadband width
    for (int d = 0; d < 4; d++) begin
      go({2'h0, d[1:0], 4'h0}, 12'h0F0, 12'h0F0 + ((d == 0) ? 12'h002 : (12'h002 << (d - 1))), 1);
      `CHK(fine, (d == 0) ? 10'h1FF : 10'h200)
    end
    // hold bit and both power-down sources freeze the codes
    for (int f = 0; f < 3; f++) begin
      pd_pin = (f == 1);
      pd_bit = (f == 2);
      go((f == 0) ? 8'h40 : 8'h00, 12'h0FF, 12'h804, 0);
      repeat (400) @(posedge sys_clk);
      #1;
      `CHK({coarse, fine}, {9'h100, 10'h200})
      `CHK(crb, (f == 0) ? 8'h40 : 8'h00)
      pd_pin = 1'b0;
      pd_bit = 1'b0;
    end
    // manual load refused when off, taken when on, then fine wraps
    restart;
    wr(4'h2, 12'h0AB);
    `CHK(coarse, 9'h100)
    wr(4'h1, 12'h080);
    wr(4'h2, 12'h0AB);
    wr(4'h3, 12'h000);
    `CHK({coarse, fine}, {9'h0AB, 10'h000})
    wr(4'h1, 12'h000);
    wr(4'h0, 12'h0FF);
    level = 12'h804;
    run = 1'b1;
    wait_done;
    @(posedge sys_clk);
    #1;
    `CHK({coarse, fine}, {9'h0AA, 10'h200})
    // two-line wait: steady iterations land exactly two lines apart
    restart;
    wr(4'h4, 12'h002);
    wr(4'h1, 12'h000);
    wr(4'h0, 12'h0FF);
    level = 12'h804;
    run = 1'b1;
    wait_done;
    wait_done;
    wait_done;
    `CHK(k, 96)
    // all pulses active high, then soft reset restores settings only
    restart;
    wr(4'h6, 12'h01F);
    pol = 5'h1F;
    `CHK(prb, 5'h1F)
    wr(4'h7, 12'h001);
    wr(4'h4, 12'h000);
    wr(4'h5, 12'h000);
    wr(4'h1, 12'h000);
    wr(4'h0, 12'h0FF);
    level = 12'h0F0;
    run = 1'b1;
    repeat (300) @(posedge sys_clk);
    // find a black pulse; tracking starts one cycle after its end is seen
    do begin
      @(posedge sys_clk);
      #1;
    end while (bsp !== 1'b1);
    repeat (2) begin
      @(posedge sys_clk);
      #1;
    end
    `CHK(vtr, 1'b0)
    @(posedge sys_clk);
    #1 run = 1'b0;
    `CHK(vtr, 1'b1)
    #1;
    `CHK(fine > 10'h200, 1'b1)
    wr(4'h8, 12'h000);
    pol = 5'h00;
    `CHK(prb, 5'h00)
    `CHK(crb, 8'h0D)
    `CHK(coarse, 9'h100)
    `CHK(fine > 10'h200, 1'b1)
    end_of_test;
  end
endmodule // test_ccd_black_level_calibration
